// >>> inc/ris_pkg.sv
// shared constants for the receiver interrupt, status and mode control block
package ris_pkg;
  // register addresses on the serial port
  localparam logic [6:0] ADDR_STATUS_FIRST = 7'h03;
  localparam logic [6:0] ADDR_STATUS_SECOND = 7'h04;
  localparam logic [6:0] ADDR_ENABLE_FIRST = 7'h05;
  localparam logic [6:0] ADDR_ENABLE_SECOND = 7'h06;
  localparam logic [6:0] ADDR_MODE_FIRST = 7'h07;
  // values after reset and implemented-bit masks
  localparam logic [7:0] STATUS_FIRST_RESET = 8'h00;
  localparam logic [7:0] STATUS_SECOND_RESET = 8'h01;
  localparam logic [7:0] ENABLE_FIRST_RESET = 8'h00;
  localparam logic [3:0] ENABLE_SECOND_RESET = 4'h3;
  localparam logic [7:0] MODE_FIRST_RESET = 8'h01;
  localparam logic [7:0] ENABLE_FIRST_MASK = 8'h9B;
  localparam logic [7:0] STATUS_FIRST_MASK = 8'h9B;
  localparam logic [7:0] MODE_FIRST_MASK = 8'h77;
  // second status group bit positions
  localparam int BIT_SYNC = 7;
  localparam int BIT_PRE_VALID = 6;
  localparam int BIT_PRE_INVALID = 5;
  localparam int BIT_RSSI = 4;
  localparam int BIT_WAKE = 3;
  localparam int BIT_LOW_BATT = 2;
  localparam int BIT_READY = 1;
  localparam int BIT_POWER_ON = 0;
  // first status group bit positions
  localparam int BIT_FIFO_ERR = 7;
  localparam int BIT_ALMOST_FULL = 4;
  localparam int BIT_EXTERNAL = 3;
  localparam int BIT_PKT_VALID = 1;
  localparam int BIT_CRC_ERR = 0;
  // first mode control bit positions
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_LOW_BATT_EN = 6;
  localparam int BIT_WAKE_EN = 5;
  localparam int BIT_SLOW_CLK_SEL = 4;
  localparam int BIT_RX_ON = 2;
  localparam int BIT_PLL_HOLD = 1;
  localparam int BIT_XTAL_ON = 0;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int XTAL_SETTLE_NS = 600000;
  localparam int XTAL_SETTLE_CYCLES = (XTAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // serial frame: r/w bit, 7 address bits, 8 data bits
  localparam logic [3:0] SPI_LAST_ADDR_BIT = 4'h7;
  localparam logic [3:0] SPI_LAST_BIT = 4'hF;
endpackage

// >>> rtl/ris_spi_port.sv
// serial register port: frame decode into read and write strobes
`timescale 1ns/10ps
module ris_spi_port (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // serial pins
  input wire logic spi_sclk_i,
  input wire logic spi_sel_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_n_o,
  // register side
  output logic rd_stb_o,
  output logic wr_stb_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] sel_s;
    logic [1:0] sdi_s;
    logic [3:0] cnt;
    logic [7:0] shin;
    logic write;
    logic [6:0] addr;
    logic [7:0] txsh;
    logic sdo;
    logic rd_stb;
    logic wr_stb;
    logic [7:0] wdata;
  } ris_spi_s;

  localparam ris_spi_s SPI_RESET = '{sclk_s: 3'h0, sel_s: 2'h3, sdi_s: 2'h0, cnt: 4'h0,
    shin: 8'h00, write: 1'b0, addr: 7'h00, txsh: 8'h00, sdo: 1'b0, rd_stb: 1'b0,
    wr_stb: 1'b0, wdata: 8'h00};

  ris_spi_s st;
  ris_spi_s next_st;
  logic sel;
  logic rise;
  logic fall;

  // edges come from the second and third stages only
  assign sel = ~st.sel_s[1];
  assign rise = st.sclk_s[1] & ~st.sclk_s[2];
  assign fall = ~st.sclk_s[1] & st.sclk_s[2];

  always_comb
  begin
    next_st = st;
    next_st.sclk_s = {st.sclk_s[1:0], spi_sclk_i};
    next_st.sel_s = {st.sel_s[0], spi_sel_n_i};
    next_st.sdi_s = {st.sdi_s[0], spi_sdi_i};
    next_st.rd_stb = 1'b0;
    next_st.wr_stb = 1'b0;
    if (!sel)
    begin
      next_st.cnt = 4'h0;
    end
    else if (rise)
    begin
      next_st.shin = {st.shin[6:0], st.sdi_s[1]};
      next_st.cnt = st.cnt + 4'h1;
      if (st.cnt == ris_pkg::SPI_LAST_ADDR_BIT)
      begin
        next_st.write = st.shin[6];
        next_st.addr = {st.shin[5:0], st.sdi_s[1]};
        next_st.rd_stb = ~st.shin[6];
      end
      if (st.cnt == ris_pkg::SPI_LAST_BIT && st.write)
      begin
        next_st.wr_stb = 1'b1;
        next_st.wdata = {st.shin[6:0], st.sdi_s[1]};
      end
    end
    else if (fall && !st.write && st.cnt[3])
    begin
      next_st.sdo = st.txsh[7];
      next_st.txsh = {st.txsh[6:0], 1'b0};
    end
    // read data is captured before the read-clear lands
    if (st.rd_stb)
    begin
      next_st.txsh = rdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st <= SPI_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign spi_sdo_o = st.sdo;
  assign spi_sdo_oe_n_o = ~(sel & ~st.write & st.cnt[3]);
  assign rd_stb_o = st.rd_stb;
  assign wr_stb_o = st.wr_stb;
  assign addr_o = st.addr;
  assign wdata_o = st.wdata;
endmodule

// >>> rtl/ris_settle_timer.sv
// crystal settling counter that drives the module-ready flag
`timescale 1ns/10ps
module ris_settle_timer #(
  parameter int CYCLES = ris_pkg::XTAL_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // control and result
  input wire logic run_i,
  output logic ready_o
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic ready;
  } ris_settle_s;

  ris_settle_s st;
  ris_settle_s next_st;

  always_comb
  begin
    next_st = st;
    if (!run_i)
    begin
      next_st.count = '0;
      next_st.ready = 1'b0;
    end
    else if (!st.ready)
    begin
      if (st.count == LAST)
      begin
        next_st.ready = 1'b1;
      end
      else
      begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign ready_o = st.ready;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_ready_needs_run: assert property (!run_i |=> !ready_o)
    else $error("ready stayed high after the crystal was dropped");
  a_ready_after_settle: assert property ($rose(ready_o) |-> $past(st.count) == LAST)
    else $error("ready rose before the settling count ran out");
endmodule

// >>> rtl/ris_irq_ctrl.sv
// interrupt status, interrupt enables and first mode control of the receiver
`timescale 1ns/10ps
module ris_irq_ctrl #(
  parameter int SETTLE_CYCLES = ris_pkg::XTAL_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // serial register pins
  input wire logic spi_sclk_i,
  input wire logic spi_sel_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_n_o,
  // receive events, second group
  input wire logic sync_found_i,
  input wire logic packet_done_i,
  input wire logic preamble_found_i,
  input wire logic sync_timeout_i,
  input wire logic preamble_invalid_i,
  input wire logic rssi_above_i,
  input wire logic wake_expired_i,
  input wire logic low_batt_event_i,
  // receive events, first group
  input wire logic fifo_error_i,
  input wire logic fifo_reset_i,
  input wire logic rx_almost_full_i,
  input wire logic external_event_i,
  input wire logic packet_valid_i,
  input wire logic crc_error_i,
  // configuration held elsewhere
  input wire logic preamble_detect_mode_i,
  input wire logic rssi_irq_mode_i,
  input wire logic multi_packet_rx_i,
  // interrupt pin and mode outputs
  output logic irq_request_n_o,
  output logic low_batt_enable_o,
  output logic wake_timer_enable_o,
  output logic slow_clock_source_sel_o,
  output logic rx_on_o,
  output logic pll_hold_o,
  output logic xtal_on_o,
  output logic module_ready_o
);
  typedef struct packed {
    logic [7:0] status_first;
    logic [7:0] status_second;
    logic [7:0] enable_first;
    logic [3:0] enable_second;
    logic [7:0] mode_first;
    logic rssi_d;
    logic almost_full_d;
    logic ready_d;
    logic irq_n;
  } ris_ctrl_s;

  localparam ris_ctrl_s CTRL_RESET = '{status_first: ris_pkg::STATUS_FIRST_RESET,
    status_second: ris_pkg::STATUS_SECOND_RESET, enable_first: ris_pkg::ENABLE_FIRST_RESET,
    enable_second: ris_pkg::ENABLE_SECOND_RESET, mode_first: ris_pkg::MODE_FIRST_RESET,
    rssi_d: 1'b0, almost_full_d: 1'b0, ready_d: 1'b0, irq_n: 1'b1};

  ris_ctrl_s st;
  ris_ctrl_s next_st;
  logic rd_stb;
  logic wr_stb;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] en_first;
  logic [7:0] en_second;
  logic [7:0] set_first;
  logic [7:0] clr_first;
  logic [7:0] set_second;
  logic [7:0] clr_second;
  logic rd_first;
  logic rd_second;
  logic mode_write;
  logic soft_reset;
  logic xtal_run;
  logic ready;

  ris_spi_port u_spi (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .spi_sclk_i(spi_sclk_i),
    .spi_sel_n_i(spi_sel_n_i),
    .spi_sdi_i(spi_sdi_i),
    .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe_n_o(spi_sdo_oe_n_o),
    .rd_stb_o(rd_stb),
    .wr_stb_o(wr_stb),
    .addr_o(addr),
    .wdata_o(wdata),
    .rdata_i(rdata)
  );

  // crystal runs in ready, tune or receive; idle drops it and the ready flag
  assign xtal_run = st.mode_first[ris_pkg::BIT_XTAL_ON] | st.mode_first[ris_pkg::BIT_PLL_HOLD]
    | st.mode_first[ris_pkg::BIT_RX_ON];
  ris_settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .run_i(xtal_run),
    .ready_o(ready)
  );

  assign en_first = st.enable_first & ris_pkg::ENABLE_FIRST_MASK;
  // upper four enables cannot be written; preamble ones follow the mode flag
  assign en_second = {{3{preamble_detect_mode_i}}, rssi_irq_mode_i,
    st.enable_second};
  assign rd_first = rd_stb && addr == ris_pkg::ADDR_STATUS_FIRST;
  assign rd_second = rd_stb && addr == ris_pkg::ADDR_STATUS_SECOND;
  assign mode_write = wr_stb && addr == ris_pkg::ADDR_MODE_FIRST;
  assign soft_reset = mode_write && wdata[ris_pkg::BIT_SOFT_RESET];

  always_comb
  begin
    set_second = 8'h00;
    clr_second = 8'h00;
    set_second[ris_pkg::BIT_SYNC] = sync_found_i;
    clr_second[ris_pkg::BIT_SYNC] = packet_done_i;
    set_second[ris_pkg::BIT_PRE_VALID] = preamble_found_i;
    clr_second[ris_pkg::BIT_PRE_VALID] = sync_found_i | sync_timeout_i;
    // masked pulse sources would be invisible if latched forever
    set_second[ris_pkg::BIT_PRE_INVALID] = preamble_invalid_i;
    clr_second[ris_pkg::BIT_PRE_INVALID] = ~en_second[ris_pkg::BIT_PRE_INVALID];
    set_second[ris_pkg::BIT_RSSI] = rssi_above_i & ~st.rssi_d;
    clr_second[ris_pkg::BIT_RSSI] = ~rssi_above_i & st.rssi_d;
    set_second[ris_pkg::BIT_WAKE] = wake_expired_i
      & st.mode_first[ris_pkg::BIT_WAKE_EN];
    clr_second[ris_pkg::BIT_WAKE] = ~en_second[ris_pkg::BIT_WAKE];
    set_second[ris_pkg::BIT_LOW_BATT] = low_batt_event_i
      & st.mode_first[ris_pkg::BIT_LOW_BATT_EN];
    set_second[ris_pkg::BIT_READY] = ready & ~st.ready_d;
    clr_second[ris_pkg::BIT_READY] = ~ready;
    set_first = 8'h00;
    clr_first = ~ris_pkg::STATUS_FIRST_MASK;
    set_first[ris_pkg::BIT_FIFO_ERR] = fifo_error_i;
    clr_first[ris_pkg::BIT_FIFO_ERR] = fifo_reset_i;
    set_first[ris_pkg::BIT_ALMOST_FULL] = rx_almost_full_i & ~st.almost_full_d;
    clr_first[ris_pkg::BIT_ALMOST_FULL] = ~rx_almost_full_i & st.almost_full_d;
    set_first[ris_pkg::BIT_EXTERNAL] = external_event_i;
    set_first[ris_pkg::BIT_PKT_VALID] = packet_valid_i;
    clr_first[ris_pkg::BIT_PKT_VALID] = sync_found_i;
    set_first[ris_pkg::BIT_CRC_ERR] = crc_error_i;
    clr_first[ris_pkg::BIT_CRC_ERR] = sync_found_i;
  end

  always_comb
  begin
    next_st = st;
    next_st.rssi_d = rssi_above_i;
    next_st.almost_full_d = rx_almost_full_i;
    next_st.ready_d = ready;
    // set wins over both the event clear and the read clear
    for (int i = 0; i < 8; i++)
    begin
      next_st.status_first[i] = set_first[i] | (st.status_first[i] & ~clr_first[i]
        & ~(rd_first & en_first[i]));
      next_st.status_second[i] = set_second[i] | (st.status_second[i] & ~clr_second[i]
        & ~(rd_second & en_second[i]));
    end
    next_st.irq_n = ~|((st.status_first & en_first) | (st.status_second & en_second));
    if (packet_valid_i && !multi_packet_rx_i)
    begin
      next_st.mode_first[ris_pkg::BIT_RX_ON] = 1'b0;
    end
    if (wr_stb && addr == ris_pkg::ADDR_ENABLE_FIRST)
    begin
      next_st.enable_first = wdata & ris_pkg::ENABLE_FIRST_MASK;
    end
    if (wr_stb && addr == ris_pkg::ADDR_ENABLE_SECOND)
    begin
      next_st.enable_second = wdata[3:0];
    end
    if (mode_write)
    begin
      next_st.mode_first = wdata & ris_pkg::MODE_FIRST_MASK;
    end
    // the reset bit is never stored, so it reads back cleared
    if (soft_reset)
    begin
      next_st = CTRL_RESET;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st <= CTRL_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    case (addr)
      ris_pkg::ADDR_STATUS_FIRST: rdata = st.status_first;
      ris_pkg::ADDR_STATUS_SECOND: rdata = st.status_second;
      ris_pkg::ADDR_ENABLE_FIRST: rdata = en_first;
      ris_pkg::ADDR_ENABLE_SECOND: rdata = en_second;
      ris_pkg::ADDR_MODE_FIRST: rdata = st.mode_first;
      default: rdata = 8'h00;
    endcase
  end

  assign irq_request_n_o = st.irq_n;
  assign low_batt_enable_o = st.mode_first[ris_pkg::BIT_LOW_BATT_EN];
  assign wake_timer_enable_o = st.mode_first[ris_pkg::BIT_WAKE_EN];
  assign slow_clock_source_sel_o = st.mode_first[ris_pkg::BIT_SLOW_CLK_SEL];
  assign rx_on_o = st.mode_first[ris_pkg::BIT_RX_ON];
  assign pll_hold_o = st.mode_first[ris_pkg::BIT_PLL_HOLD];
  assign xtal_on_o = st.mode_first[ris_pkg::BIT_XTAL_ON];
  assign module_ready_o = st.status_second[ris_pkg::BIT_READY];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_sync_rise: assert property (sync_found_i && !soft_reset
    |=> st.status_second[ris_pkg::BIT_SYNC])
    else $error("sync status did not rise");
  a_sync_drop: assert property (packet_done_i && !sync_found_i
    |=> !st.status_second[ris_pkg::BIT_SYNC])
    else $error("sync status did not drop at packet end");
  a_preamble_drop: assert property ((sync_found_i || sync_timeout_i) && !preamble_found_i
    |=> !st.status_second[ris_pkg::BIT_PRE_VALID])
    else $error("preamble status did not drop");
  a_invalid_self_clear: assert property (!en_second[ris_pkg::BIT_PRE_INVALID]
    && !preamble_invalid_i |=> !st.status_second[ris_pkg::BIT_PRE_INVALID])
    else $error("masked invalid preamble status stayed high");
  a_rssi_follow: assert property ($rose(rssi_above_i) && !soft_reset
    |=> st.status_second[ris_pkg::BIT_RSSI])
    else $error("signal strength status missed the level");
  // a soft reset one cycle later legally wipes the latched event
  a_low_batt_latch: assert property (set_second[ris_pkg::BIT_LOW_BATT] && !soft_reset
    && !en_second[ris_pkg::BIT_LOW_BATT] |=> st.status_second[ris_pkg::BIT_LOW_BATT]
    ##1 (st.status_second[ris_pkg::BIT_LOW_BATT] || $past(soft_reset)))
    else $error("masked low battery event was not kept");
  a_batt_gate: assert property (low_batt_event_i && !st.mode_first[ris_pkg::BIT_LOW_BATT_EN]
    && !st.status_second[ris_pkg::BIT_LOW_BATT] |=> !st.status_second[ris_pkg::BIT_LOW_BATT])
    else $error("low battery event taken while the detector was off");
  a_wake_gate: assert property (wake_expired_i && !st.mode_first[ris_pkg::BIT_WAKE_EN]
    && !st.status_second[ris_pkg::BIT_WAKE] |=> !st.status_second[ris_pkg::BIT_WAKE])
    else $error("wake expiry taken while the timer was off");
  a_rssi_drop: assert property ($fell(rssi_above_i) |=> !st.status_second[ris_pkg::BIT_RSSI])
    else $error("signal strength status outlived the level");
  a_ready_idle: assert property (!xtal_run |-> ##2 !module_ready_o)
    else $error("module ready stayed high in idle");
  a_irq_low: assert property (|((st.status_first & en_first) | (st.status_second & en_second))
    && !soft_reset |=> !irq_request_n_o)
    else $error("enabled pending status did not pull the pin low");
  a_enable2_write: assert property (wr_stb && addr == ris_pkg::ADDR_ENABLE_SECOND
    |=> st.enable_second == $past(wdata[3:0]))
    else $error("writable enable nibble not stored");
  a_rx_multi_keep: assert property (packet_valid_i && multi_packet_rx_i && rx_on_o
    && !mode_write |=> rx_on_o)
    else $error("manual receive dropped although multi packet is on");
  a_read_clear: assert property (rd_second && set_second == 8'h00 && !soft_reset
    |=> (st.status_second & $past(en_second)) == 8'h00)
    else $error("read left an enabled status bit set");
  a_status_kept: assert property (rd_first && clr_first == ~ris_pkg::STATUS_FIRST_MASK
    && !soft_reset |=> ($past(st.status_first) & ~$past(en_first) & ~st.status_first)
    == 8'h00)
    else $error("read cleared a masked status bit");
  a_soft_reset: assert property (soft_reset |=> st.enable_first == ris_pkg::ENABLE_FIRST_RESET
    && st.mode_first == ris_pkg::MODE_FIRST_RESET ##1 !st.mode_first[7])
    else $error("soft reset did not restore defaults");
  a_rx_auto_clear: assert property (packet_valid_i && !multi_packet_rx_i && !mode_write
    |=> !rx_on_o)
    else $error("manual receive not cleared after a single packet");
  a_reserved_zero: assert property (wr_stb |=> (rdata & ~ris_pkg::ENABLE_FIRST_MASK) == 8'h00
    || addr != ris_pkg::ADDR_ENABLE_FIRST)
    else $error("reserved enable bits read back nonzero");
endmodule

// >>> verification/ris_host_model.sv
// host controller model that runs register frames on the serial pins
`timescale 1ns/10ps
module ris_host_model (
  // clock
  input wire logic ref_clk_i,
  // serial pins
  output logic spi_sclk_o,
  output logic spi_sel_n_o,
  output logic spi_sdi_o,
  input wire logic spi_sdo_i,
  input wire logic spi_sdo_oe_n_i
);
  // half period of six clocks keeps above the four-clock minimum
  localparam int HALF = 6;
  initial
  begin
    spi_sclk_o = 1'b0;
    spi_sel_n_o = 1'b1;
    spi_sdi_o = 1'b1;
  end
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] f;
    f = {wr, a, wd};
    rd = 8'h00;
    @(negedge ref_clk_i);
    spi_sel_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_sdi_o = f[i];
      repeat (HALF) @(negedge ref_clk_i);
      // an undriven data pin must not pass for a bit
      if (i < 8)
        rd = {rd[6:0], spi_sdo_oe_n_i ? 1'bx : spi_sdo_i};
      spi_sclk_o = 1'b1;
      repeat (HALF) @(negedge ref_clk_i);
      spi_sclk_o = 1'b0;
    end
    repeat (HALF) @(negedge ref_clk_i);
    spi_sel_n_o = 1'b1;
    spi_sdi_o = ~spi_sdi_o;
    repeat (HALF) @(negedge ref_clk_i);
  endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the receiver interrupt, status and mode block
`timescale 1ns/10ps
module tb_top;
  localparam int SETTLE = 40;
  localparam logic [6:0] S1 = ris_pkg::ADDR_STATUS_FIRST;
  localparam logic [6:0] S2 = ris_pkg::ADDR_STATUS_SECOND;
  localparam logic [6:0] E1 = ris_pkg::ADDR_ENABLE_FIRST;
  localparam logic [6:0] E2 = ris_pkg::ADDR_ENABLE_SECOND;
  localparam logic [6:0] MD = ris_pkg::ADDR_MODE_FIRST;
  logic ref_clk_i;
  logic resetn_i;
  logic sclk, sel_n, sdi, sdo, sdo_oe_n;
  // [7:0] second group, [15:8] first group, 16 packet end, 17 sync timeout, 18 fifo reset
  logic [18:0] ev;
  logic pre_mode, rssi_mode, multi_pkt;
  logic irq_n, lb_en, wk_en, slow_sel, rx_on, pll, xtal, ready;
  logic [7:0] rd;
  int fail_count;
  int n_compared;

  ris_irq_ctrl #(.SETTLE_CYCLES(SETTLE)) i_ris_irq_ctrl (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .spi_sclk_i(sclk), .spi_sel_n_i(sel_n), .spi_sdi_i(sdi),
    .spi_sdo_o(sdo), .spi_sdo_oe_n_o(sdo_oe_n),
    .sync_found_i(ev[7]), .packet_done_i(ev[16]), .preamble_found_i(ev[6]),
    .sync_timeout_i(ev[17]), .preamble_invalid_i(ev[5]), .rssi_above_i(ev[4]),
    .wake_expired_i(ev[3]), .low_batt_event_i(ev[2]),
    .fifo_error_i(ev[15]), .fifo_reset_i(ev[18]), .rx_almost_full_i(ev[12]),
    .external_event_i(ev[11]), .packet_valid_i(ev[9]), .crc_error_i(ev[8]),
    .preamble_detect_mode_i(pre_mode), .rssi_irq_mode_i(rssi_mode),
    .multi_packet_rx_i(multi_pkt), .irq_request_n_o(irq_n),
    .low_batt_enable_o(lb_en), .wake_timer_enable_o(wk_en),
    .slow_clock_source_sel_o(slow_sel), .rx_on_o(rx_on), .pll_hold_o(pll),
    .xtal_on_o(xtal), .module_ready_o(ready));

  ris_host_model i_ris_host_model (
    .ref_clk_i(ref_clk_i), .spi_sclk_o(sclk), .spi_sel_n_o(sel_n),
    .spi_sdi_o(sdi), .spi_sdo_i(sdo), .spi_sdo_oe_n_i(sdo_oe_n));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_ris_host_model.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    i_ris_host_model.xfer(1'b0, a, 8'h00, rd);
    chk(rd, e);
  endtask
  // pulse keeps any level already held on the other event lines
  task automatic pulse(input logic [18:0] m);
    @(negedge ref_clk_i);
    ev = ev | m;
    @(negedge ref_clk_i);
    ev = ev & ~m;
    cyc(2);
  endtask

  task automatic t_reset;
    chk(irq_n, 8'h00);
    chk(xtal, 8'h01);
    rdc(S2, 8'h03);
    chk(irq_n, 8'h01);
    rdc(S2, 8'h00);
    rdc(E1, 8'h00);
    rdc(E2, 8'h03);
    rdc(MD, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(E1, 8'hFF);
    rdc(E1, 8'h9B);
    wr(E2, 8'hF0);
    rdc(E2, 8'h00);
    pre_mode = 1'b1;
    rssi_mode = 1'b1;
    rdc(E2, 8'hF0);
    pre_mode = 1'b0;
    rssi_mode = 1'b0;
    wr(7'h10, 8'hFF);
    rdc(7'h10, 8'h00);
    wr(E1, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_mode;
    wr(MD, 8'h7F);
    rdc(MD, 8'h77);
    chk({lb_en, wk_en, slow_sel, rx_on, pll, xtal}, 8'h3F);
    wr(MD, 8'h10);
    chk({lb_en, wk_en, slow_sel, rx_on, pll, xtal}, 8'h08);
    chk(ready, 8'h00);
    $display("test mode done");
  endtask
  task automatic t_ready;
    rdc(S2, 8'h00);
    wr(MD, 8'h02);
    chk(ready, 8'h00);
    cyc(SETTLE);
    chk(ready, 8'h01);
    rdc(S2, 8'h02);
    rdc(S2, 8'h02);
    wr(MD, 8'h00);
    chk(ready, 8'h00);
    rdc(S2, 8'h00);
    $display("test ready done");
  endtask
  task automatic t_lowbatt;
    pulse(19'h00004);
    rdc(S2, 8'h00);
    wr(MD, 8'h40);
    pulse(19'h00004);
    chk(irq_n, 8'h01);
    rdc(S2, 8'h04);
    wr(E2, 8'h04);
    chk(irq_n, 8'h00);
    rdc(S2, 8'h04);
    chk(irq_n, 8'h01);
    rdc(S2, 8'h00);
    $display("test low battery done");
  endtask
  task automatic t_wake;
    wr(MD, 8'h20);
    wr(E2, 8'h00);
    pulse(19'h00008);
    rdc(S2, 8'h00);
    pulse(19'h00020);
    rdc(S2, 8'h00);
    wr(E2, 8'h08);
    wr(MD, 8'h00);
    pulse(19'h00008);
    chk(irq_n, 8'h01);
    wr(MD, 8'h20);
    pulse(19'h00008);
    chk(irq_n, 8'h00);
    rdc(S2, 8'h08);
    pre_mode = 1'b1;
    pulse(19'h00020);
    chk(irq_n, 8'h00);
    rdc(S2, 8'h20);
    chk(irq_n, 8'h01);
    pre_mode = 1'b0;
    $display("test wake done");
  endtask
  task automatic t_events;
    pulse(19'h00040);
    rdc(S2, 8'h40);
    pulse(19'h00080);
    rdc(S2, 8'h80);
    pulse(19'h10000);
    rdc(S2, 8'h00);
    pulse(19'h00040);
    pulse(19'h20000);
    rdc(S2, 8'h00);
    ev[4] = 1'b1;
    rdc(S2, 8'h10);
    rdc(S2, 8'h10);
    ev[4] = 1'b0;
    rdc(S2, 8'h00);
    rssi_mode = 1'b1;
    ev[4] = 1'b1;
    cyc(3);
    chk(irq_n, 8'h00);
    rdc(S2, 8'h10);
    chk(irq_n, 8'h01);
    ev[4] = 1'b0;
    rssi_mode = 1'b0;
    rdc(S2, 8'h00);
    $display("test receive events done");
  endtask
  task automatic t_first;
    logic [7:0] b;
    wr(E1, 8'h9B);
    wr(MD, 8'h04);
    for (int k = 0; k < 8; k++)
    begin
      b = 8'h01 << k;
      if ((b & ris_pkg::STATUS_FIRST_MASK) != 8'h00)
      begin
        @(negedge ref_clk_i);
        ev[15:8] = b;
        @(negedge ref_clk_i);
        // almost full is a level: hold it through the read
        ev[15:8] = b & 8'h10;
        cyc(2);
        chk(irq_n, 8'h00);
        rdc(S1, b);
        ev[15:8] = 8'h00;
        cyc(2);
        chk(irq_n, 8'h01);
      end
    end
    chk(rx_on, 8'h01);
    multi_pkt = 1'b0;
    pulse(19'h00200);
    chk(rx_on, 8'h00);
    rdc(S1, 8'h02);
    wr(E1, 8'h00);
    pulse(19'h08000);
    chk(irq_n, 8'h01);
    rdc(S1, 8'h80);
    pulse(19'h40000);
    rdc(S1, 8'h00);
    $display("test first group done");
  endtask
  task automatic t_soft;
    wr(E1, 8'h9B);
    wr(MD, 8'h80);
    chk(irq_n, 8'h00);
    rdc(MD, 8'h01);
    rdc(E1, 8'h00);
    rdc(E2, 8'h03);
    rdc(S2, 8'h03);
    $display("test soft reset done");
  endtask

  initial
  begin
    fail_count = 0;
    n_compared = 0;
    resetn_i = 1'b0;
    ev = '0;
    pre_mode = 1'b0;
    rssi_mode = 1'b0;
    multi_pkt = 1'b1;
    cyc(5);
    resetn_i = 1'b1;
    cyc(3);
    t_reset;
    t_regs;
    t_mode;
    t_ready;
    t_lowbatt;
    t_wake;
    t_events;
    t_first;
    t_soft;
    test_done;
  end

  // about 60 frames of some 200 clocks each fit well inside this span
  initial
  begin
    #3000000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done;
  end
endmodule
